// file: ccop_unit.sv
// Decode and execute of clear-operand and three register/immediate compares.
// Assumes the pipeline has fetched the effective-address operand, the
// selected register value and extension words before raising req_valid.
// Operation
// - Clear writes zero, flags N0 Z1 V0 C0
// - Clear size bits 7:6 byte word long
// - Clear takes only data alterable destinations
// - Compares set NZVC from difference, keep X
// - Data compare leaves data register unchanged
// - Data compare opmode 000/001/010 picks size
// - Data compare: address source word/long only
// - Address compare flags only, word/long only
// - Address compare word source sign-extended
// - Address compare accepts every source mode up to immediate (111/100)
// - Immediate compare sizes 00/01/10, flags only
// - Four compare encodings decoded as distinct kinds
// - Immediate taken from extension words by size
// - Immediate compare rejects address, immediate destinations
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`include "ccop_params.svh"
module ccop_unit (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic req_valid,
  input wire ccop_pkg::ccop_req_s req,
  output ccop_pkg::ccop_res_s res,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  ////////////////////////////////////////////////////////////////////////////
  ccop_pkg::ccop_res_s res_r, res_nxt;
  logic ctrl_en_r, ctrl_en_nxt;
  logic ill_r, ill_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic acc;
  logic [2:0] md;
  logic [2:0] rg;
  logic [1:0] sz;
  logic [2:0] opm;
  logic ill_clr;

  assign res = res_r;
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign acc = req_valid & ctrl_en_r;
  assign md = req.iw[5:3];
  assign rg = req.iw[2:0];
  assign sz = req.iw[7:6];
  assign opm = req.iw[8:6];

  // Returns {N,Z,V,C} of d - s at the given size
  function automatic logic [3:0] cmp_flags(input logic [31:0] d, input logic [31:0] s,
                                           input logic [1:0] size);
    logic [32:0] df;
    logic n;
    logic z;
    logic v;
    logic c;
    df = {1'b0, d} - {1'b0, s};
    case (size)
      2'b00: begin
        n = df[7];
        z = (df[7:0] == 8'h00);
        c = d[7:0] < s[7:0];
        v = (d[7] ^ s[7]) & (d[7] ^ df[7]);
      end
      2'b01: begin
        n = df[15];
        z = (df[15:0] == 16'h0000);
        c = d[15:0] < s[15:0];
        v = (d[15] ^ s[15]) & (d[15] ^ df[15]);
      end
      default: begin
        n = df[31];
        z = (df[31:0] == 32'h0000_0000);
        c = df[32];
        v = (d[31] ^ s[31]) & (d[31] ^ df[31]);
      end
    endcase
    return {n, z, v, c};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Execute path
  always_comb begin
    logic [31:0] imm;
    logic [3:0] fl;
    logic am_ok;
    res_nxt = res_r;
    res_nxt.valid = 1'b0;
    // Write-one clear; a new illegal request below overrides it
    ill_nxt = ill_clr ? 1'b0 : ill_r;
    cnt_nxt = cnt_r;
    imm = 32'h0000_0000;
    fl = 4'h0;
    am_ok = 1'b0;
    if (acc) begin
      res_nxt.valid = 1'b1;
      res_nxt.kind = ccop_pkg::KIND_NONE;
      res_nxt.illegal = 1'b1;
      res_nxt.ccr = req.ccr_in;
      res_nxt.wr_en = 1'b0;
      res_nxt.wr_data = 32'h0000_0000;
      res_nxt.wr_size = sz;
      if (req.iw[15:8] == 8'h42 && sz != 2'b11) begin
        res_nxt.kind = ccop_pkg::KIND_CLR;
        am_ok = (md == 3'b000) || (md >= 3'b010 && md <= 3'b110) ||
                (md == 3'b111 && rg <= 3'b001);
        if (am_ok) begin
          res_nxt.illegal = 1'b0;
          res_nxt.wr_en = 1'b1;
          res_nxt.wr_size = sz;
          res_nxt.ccr = {req.ccr_in[`CCOP_CC_X], 4'b0100};
        end
      end else if (req.iw[15:12] == 4'hB && req.iw[8] && sz != 2'b11 && md == 3'b001) begin
        // Opmodes 100/101/110 with mode 001, no overlap with the data opmodes; executed elsewhere
        res_nxt.kind = ccop_pkg::KIND_COMPARE_MEMORY_TO_MEMORY_INSTR;
      end else if (req.iw[15:12] == 4'hB && (opm == 3'b011 || opm == 3'b111)) begin
        res_nxt.kind = ccop_pkg::KIND_COMPARE_ADDRESS_REG_INSTR;
        am_ok = (md != 3'b111) || (rg <= 3'b100);
        if (am_ok) begin
          res_nxt.illegal = 1'b0;
          res_nxt.wr_size = 2'b10;
          imm = (opm == 3'b011) ? {{16{req.ea_val[15]}}, req.ea_val[15:0]} :
                req.ea_val;
          fl = cmp_flags(req.reg_val, imm, 2'b10);
          res_nxt.ccr = {req.ccr_in[`CCOP_CC_X], fl};
        end
      end else if (req.iw[15:12] == 4'hB && opm <= 3'b010) begin
        res_nxt.kind = ccop_pkg::KIND_CMP;
        am_ok = ((md != 3'b111) || (rg <= 3'b100)) &&
                !(md == 3'b001 && opm == 3'b000);
        if (am_ok) begin
          res_nxt.illegal = 1'b0;
          res_nxt.wr_size = opm[1:0];
          fl = cmp_flags(req.reg_val, req.ea_val, opm[1:0]);
          res_nxt.ccr = {req.ccr_in[`CCOP_CC_X], fl};
        end
      end else if (req.iw[15:8] == 8'h0C && sz != 2'b11) begin
        res_nxt.kind = ccop_pkg::KIND_COMPARE_IMMEDIATE_INSTR;
        am_ok = (md == 3'b000) || (md >= 3'b010 && md <= 3'b110) ||
                (md == 3'b111 && rg <= 3'b011);
        case (sz)
          2'b00: imm = {24'h00_0000, req.ext[23:16]};
          2'b01: imm = {16'h0000, req.ext[31:16]};
          default: imm = req.ext;
        endcase
        if (am_ok) begin
          res_nxt.illegal = 1'b0;
          fl = cmp_flags(req.ea_val, imm, sz);
          res_nxt.ccr = {req.ccr_in[`CCOP_CC_X], fl};
        end
      end
      if (res_nxt.illegal) begin
        ill_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 32'h0000_0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, so every answer comes from a flop
  always_comb begin
    logic hit;
    hit = psel & penable & ~pready_r;
    ctrl_en_nxt = ctrl_en_r;
    pready_nxt = hit;
    pslverr_nxt = 1'b0;
    prdata_nxt = 32'h0000_0000;
    if (hit) begin
      case (paddr)
        `CCOP_OFF_CTRL: begin
          prdata_nxt = {31'h0000_0000, ctrl_en_r};
          if (pwrite) begin
            ctrl_en_nxt = pwdata[`CCOP_CTRL_EN_BIT];
          end
        end
        `CCOP_OFF_STAT: begin
          prdata_nxt = {23'h00_0000, ill_r, res_r.kind, res_r.ccr};
        end
        `CCOP_OFF_CNT: begin
          prdata_nxt = cnt_r;
        end
        default: begin
          pslverr_nxt = 1'b1;
        end
      endcase
    end
  end

  // Sticky illegal flag: write one clears, a new illegal in the same cycle wins
  assign ill_clr = psel & penable & ~pready_r & pwrite & (paddr == `CCOP_OFF_STAT) &
                   pwdata[`CCOP_STAT_ILL_BIT];

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      res_r <= '0;
      ill_r <= 1'b0;
      cnt_r <= `CCOP_CNT_RST;
      ctrl_en_r <= `CCOP_CTRL_RST;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else if (ce) begin
      res_r <= res_nxt;
      ill_r <= ill_nxt;
      cnt_r <= cnt_nxt;
      ctrl_en_r <= ctrl_en_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  logic acc_d_r;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      acc_d_r <= 1'b0;
    end else begin
      acc_d_r <= ce & acc;
    end
  end

  a_clr_flags: assert property (ce && acc && req.iw[15:8] == 8'h42 && sz != 2'b11 &&
    md == 3'b000 |=> res.valid && res.wr_en && res.wr_data == 32'h0000_0000 &&
    res.ccr[3:0] == 4'b0100 && res.ccr[4] == $past(req.ccr_in[4]))
    else $error("clear gave wrong flags or data");
  a_clr_size: assert property (ce && acc && req.iw[15:8] == 8'h42 && md == 3'b000 &&
    sz != 2'b11 |=> res.wr_size == $past(req.iw[7:6]))
    else $error("clear size mismatch");
  a_clr_no_an: assert property (ce && acc && req.iw[15:8] == 8'h42 &&
    md == 3'b001 |=> res.illegal && !res.wr_en)
    else $error("clear took an address register");
  a_x_kept: assert property (acc_d_r |-> res.ccr[4] == $past(req.ccr_in[4]))
    else $error("extend flag changed");
  a_cmp_nowrite: assert property (res.valid && res.kind != ccop_pkg::KIND_CLR
    |-> !res.wr_en)
    else $error("compare wrote a destination");
  a_cmp_byte_an: assert property (ce && acc && req.iw[15:12] == 4'hB &&
    opm == 3'b000 && md == 3'b001 |=> res.illegal)
    else $error("byte compare took address source");
  a_compare_address_reg_instr_sext: assert property (ce && acc && req.iw[15:12] == 4'hB && opm == 3'b011 &&
    md == 3'b000 && req.reg_val == 32'hFFFF_8000 && req.ea_val[15:0] == 16'h8000
    |=> res.ccr[2] && !res.ccr[0])
    else $error("word source not sign-extended");
  a_compare_immediate_instr_imm_dst: assert property (ce && acc && req.iw[15:8] == 8'h0C &&
    md == 3'b111 && rg == 3'b100 |=> res.illegal)
    else $error("immediate compare took immediate destination");
  a_apb_wait: assert property (ce && psel && penable && !pready
    |=> pready ##1 !pready)
    else $error("apb answer timing wrong");

  c_clr_done: cover property (res.valid && res.kind == ccop_pkg::KIND_CLR && !res.illegal);
  c_compare_address_reg_instr_done: cover property (res.valid && res.kind == ccop_pkg::KIND_COMPARE_ADDRESS_REG_INSTR && !res.illegal);
  c_compare_immediate_instr_done: cover property (res.valid && res.kind == ccop_pkg::KIND_COMPARE_IMMEDIATE_INSTR && !res.illegal);
  c_illegal: cover property (res.valid && res.illegal);
endmodule

// file: ccop_params.svh
// Constants for the clear and compare execute unit.
// Assumes inclusion by the package and the unit only.
`ifndef CCOP_PARAMS_SVH
`define CCOP_PARAMS_SVH
`define CCOP_OFF_CTRL 12'h000
`define CCOP_OFF_STAT 12'h004
`define CCOP_OFF_CNT 12'h008
`define CCOP_CTRL_EN_BIT 0
`define CCOP_STAT_ILL_BIT 8
`define CCOP_CTRL_RST 1'b1
`define CCOP_CNT_RST 32'h0000_0000
`define CCOP_CC_X 4
`define CCOP_CC_N 3
`define CCOP_CC_Z 2
`define CCOP_CC_V 1
`define CCOP_CC_C 0
`define CCOP_APB_WAIT 1
`endif

// file: ccop_pkg.sv
// Types for the clear and compare execute unit.
// Assumes the params header is on the include path.
`include "ccop_params.svh"
package ccop_pkg;
  typedef enum logic [2:0] {
    KIND_NONE = 3'b000,
    KIND_CLR = 3'b001,
    KIND_CMP = 3'b010,
    KIND_COMPARE_ADDRESS_REG_INSTR = 3'b011,
    KIND_COMPARE_IMMEDIATE_INSTR = 3'b100,
    KIND_COMPARE_MEMORY_TO_MEMORY_INSTR = 3'b101
  } ccop_kind_e;
  typedef struct packed {
    logic [15:0] iw;
    logic [31:0] ext;
    logic [31:0] ea_val;
    logic [31:0] reg_val;
    logic [4:0] ccr_in;
  } ccop_req_s;
  typedef struct packed {
    logic valid;
    ccop_kind_e kind;
    logic illegal;
    logic [4:0] ccr;
    logic wr_en;
    logic [31:0] wr_data;
    logic [1:0] wr_size;
  } ccop_res_s;
endpackage

// file: clear_and_compare_ops_test.sv
// Self-checking bench for the clear and compare unit, with a reference model.
// Assumes ccop_pkg and ccop_unit are compiled first.
`timescale 1ns/1ns
module clear_and_compare_ops_test;
  logic sys_clk = 0;
  logic nrst = 0;
  logic ce = 1;
  logic req_valid = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er;
  ccop_pkg::ccop_req_s req = '0;
  ccop_pkg::ccop_res_s res;
  ccop_pkg::ccop_res_s expq[$];
  int miscompares = 0;
  int checks = 0;
  int seed = 32'h67e4;
  int nleg = 0;
  int nill = 0;
  always #25 sys_clk = ~sys_clk;
  ccop_unit uut (.sys_clk(sys_clk), .nrst(nrst), .ce(ce), .req_valid(req_valid), .req(req),
    .res(res), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask
  // Master holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      miscompares++;
      close_out();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [3:0] nzvc(input logic [31:0] d, input logic [31:0] s, input int w);
    logic [31:0] m, r;
    int t;
    m = 32'hFFFF_FFFF >> (32 - w);
    t = w - 1;
    d = d & m;
    s = s & m;
    r = (d - s) & m;
    return {r[t], r == 0, (d[t] ^ s[t]) & (r[t] ^ d[t]), s > d};
  endfunction
  function automatic ccop_pkg::ccop_res_s model(input ccop_pkg::ccop_req_s q);
    ccop_pkg::ccop_res_s e;
    logic [2:0] md, rg, op;
    logic [1:0] sz;
    logic [31:0] s, d;
    int w;
    logic bad;
    e = '0;
    md = q.iw[5:3];
    rg = q.iw[2:0];
    op = q.iw[8:6];
    sz = q.iw[7:6];
    s = q.ea_val;
    d = q.reg_val;
    w = 32;
    if (q.iw[15:8] == 8'h42) begin
      e.kind = ccop_pkg::KIND_CLR;
      bad = sz == 2'b11 || md == 3'd1 || (md == 3'd7 && rg > 3'd1);
      e.wr_en = 1'b1;
      e.wr_size = sz;
    end else if (q.iw[15:8] == 8'h0C) begin
      e.kind = ccop_pkg::KIND_COMPARE_IMMEDIATE_INSTR;
      bad = sz == 2'b11 || md == 3'd1 || (md == 3'd7 && rg > 3'd3);
      d = q.ea_val;
      s = sz == 2'b00 ? q.ext[23:16] : (sz == 2'b01 ? q.ext[31:16] : q.ext);
      w = 8 << sz;
    end else if (op == 3'd3 || op == 3'd7) begin
      e.kind = ccop_pkg::KIND_COMPARE_ADDRESS_REG_INSTR;
      bad = md == 3'd7 && rg > 3'd4;
      s = op == 3'd3 ? {{16{q.ea_val[15]}}, q.ea_val[15:0]} : q.ea_val;
    end else if (op[2]) begin
      e.kind = ccop_pkg::KIND_COMPARE_MEMORY_TO_MEMORY_INSTR;
      bad = 1'b1;
    end else begin
      e.kind = ccop_pkg::KIND_CMP;
      bad = (op == 3'd0 && md == 3'd1) || (md == 3'd7 && rg > 3'd4);
      w = 8 << op[1:0];
    end
    e.ccr = e.wr_en ? {q.ccr_in[4], 4'b0100} : {q.ccr_in[4], nzvc(d, s, w)};
    if (bad) begin
      e.ccr = q.ccr_in;
      e.wr_en = 1'b0;
      e.illegal = 1'b1;
    end
    return e;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  task automatic gen(output ccop_pkg::ccop_req_s q);
    logic [31:0] r;
    logic [2:0] op;
    r = $random(seed);
    q.ext = $random(seed);
    q.ea_val = $random(seed);
    q.reg_val = r[13] ? q.ea_val : $random(seed);
    q.ccr_in = r[20:16];
    if (r[14]) begin
      q.ext = {q.ea_val[15:0], q.ea_val[15:0]};
    end
    op = r[3:2] == 2'b11 ? 3'b101 : {r[2], 2'b11};
    case (r[1:0])
      2'd0: q.iw = {8'h42, r[3:2], r[6:4], r[9:7]};
      2'd1: q.iw = {8'h0C, r[3:2], r[6:4], r[9:7]};
      2'd2: q.iw = {4'hB, r[12:10], 1'b0, r[3:2], r[6:4], r[9:7]};
      default: q.iw = {4'hB, r[12:10], op, op[2] ? 3'd1 : r[6:4], r[9:7]};
    endcase
  endtask
  // Result of the previous request is seen just after this edge
  task automatic step(input ccop_pkg::ccop_req_s q, input logic v, input logic take);
    ccop_pkg::ccop_res_s e;
    @(posedge sys_clk);
    req <= q;
    req_valid <= v;
    #1;
    if (expq.size() > 0) begin
      e = expq.pop_front();
      chk("valid", 1, res.valid);
      chk("illegal", e.illegal, res.illegal);
      chk("ccr", e.ccr, res.ccr);
      chk("wr_en", e.wr_en, res.wr_en);
      if (!e.illegal) chk("kind", e.kind, res.kind);
      if (e.wr_en) chk("wr_size", e.wr_size, res.wr_size);
      if (e.wr_en) chk("wr_data", 0, res.wr_data);
    end else begin
      chk("idle", 0, res.valid);
    end
    if (take) begin
      e = model(q);
      expq.push_back(e);
      if (e.illegal) nill++;
      else nleg++;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ccop_pkg::ccop_req_s q;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    apb(0, 12'h000, 0);
    chk("ctrl", 1, rd);
    apb(0, 12'h004, 0);
    chk("stat", 0, rd);
    apb(0, 12'h00C, 0);
    chk("slverr", 1, er);
    $display("test reset and map done");
    repeat (300) begin
      gen(q);
      step(q, 1'b1, 1'b1);
    end
    q.iw = 16'hB0C0;
    q.reg_val = 32'hFFFF_8000;
    q.ea_val = 32'h0000_8000;
    step(q, 1'b1, 1'b1);
    q.iw = 16'h4280;
    step(q, 1'b1, 1'b1);
    step(q, 1'b0, 1'b0);
    $display("test random stream done, illegal %0d", nill);
    apb(0, 12'h004, 0);
    chk("stat", {23'h0, nill > 0, 3'd1, q.ccr_in[4], 4'b0100}, rd);
    apb(0, 12'h008, 0);
    chk("cnt", nleg, rd);
    apb(1, 12'h004, 32'h0000_0100);
    apb(0, 12'h004, 0);
    chk("sticky", 0, rd[8]);
    apb(1, 12'h000, 0);
    step(q, 1'b1, 1'b0);
    step(q, 1'b0, 1'b0);
    apb(1, 12'h000, 1);
    @(posedge sys_clk);
    ce <= 1'b0;
    step(q, 1'b1, 1'b0);
    step(q, 1'b1, 1'b0);
    // Drop the held request so that only the next step's request is taken
    @(posedge sys_clk);
    ce <= 1'b1;
    req_valid <= 1'b0;
    step(q, 1'b1, 1'b1);
    step(q, 1'b0, 1'b0);
    apb(0, 12'h008, 0);
    chk("cnt", nleg, rd);
    $display("test disable and freeze done");
    close_out();
  end
endmodule
